// File: rtl/ext_irq_bank_pkg.sv
// Types shared by the extended interrupt bank
package ext_irq_bank_pkg;

  typedef logic [1:0] prio_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_REQ = 3'b010,
    ST_HOLD = 3'b100
  } arb_state_t;

endpackage : ext_irq_bank_pkg

// File: rtl/ext_irq_bank_regs.svh
// Register offsets, field positions and reset values of the extended interrupt bank
`ifndef EXT_IRQ_BANK_REGS_SVH
`define EXT_IRQ_BANK_REGS_SVH

`define SFR_PAGE_EXT 8'h10
`define SFR_PAGE_BASE 8'h00
`define ADDR_MASK_TWO 8'hCE
`define ADDR_MASK_ONE 8'hE6
`define ADDR_PRIO_ONE_LOW 8'hF3
`define ADDR_PRIO_TWO_LOW 8'hF4
`define ADDR_PRIO_ONE_HIGH 8'hF5
`define ADDR_PRIO_TWO_HIGH 8'hF6

`define RST_MASK_TWO 8'h00
`define RST_PRIO 8'h00

// Writable bits of the second-bank registers; 5:4 are reserved
`define WMASK_TWO 8'hCF
`define WMASK_PRIO_TWO 8'hCF

`define BIT_CFG_LOGIC 6
`define BIT_TIMER5 3
`define BIT_TIMER4 2
`define BIT_SUPPLY 1
`define BIT_USB 0

`endif

// File: rtl/ext_irq_enable_priority_bank.sv
// Extended interrupt enable and four-level priority bank with request arbiter

module ext_irq_enable_priority_bank #(
  parameter int NUM_SRC = 13
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RESETN,
  // Special-function register port
  input wire logic [7:0] I_SFR_PAGE,
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic I_SFR_WR,
  input wire logic I_SFR_RD,
  input wire logic [7:0] I_SFR_WDATA,
  output logic [7:0] O_SFR_RDATA,
  output logic O_SFR_HIT,
  // Peripheral request flags
  input wire logic [7:0] I_BANK_ONE_FLAGS,
  input wire logic I_TIMER5_LOW_OVERFLOW_FLAG,
  input wire logic I_TIMER5_HIGH_OVERFLOW_FLAG,
  input wire logic I_TIMER4_LOW_OVERFLOW_FLAG,
  input wire logic I_TIMER4_HIGH_OVERFLOW_FLAG,
  input wire logic I_CFG_LOGIC_FLAG,
  input wire logic I_SUPPLY_DETECT_FLAG,
  input wire logic I_USB_FLAG,
  // Core sequencer
  input wire logic [1:0] I_ACTIVE_LEVEL,
  input wire logic I_IN_SERVICE,
  output logic O_IRQ_REQ,
  output logic [3:0] O_IRQ_ID,
  output logic [1:0] O_IRQ_LEVEL
);

  `include "ext_irq_bank_regs.svh"

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] mask_one_q;
  logic [7:0] mask_two_q;
  logic [7:0] prio_one_low_q;
  logic [7:0] prio_two_low_q;
  logic [7:0] prio_one_high_q;
  logic [7:0] prio_two_high_q;

  // First-bank mask and low-priority registers are visible on both pages, the high-priority one only on the extended page
  wire page_ext = (I_SFR_PAGE == `SFR_PAGE_EXT);
  wire page_any = page_ext || (I_SFR_PAGE == `SFR_PAGE_BASE);
  wire sel_mask_one = page_any && (I_SFR_ADDR == `ADDR_MASK_ONE);
  wire sel_prio_one_low = page_any && (I_SFR_ADDR == `ADDR_PRIO_ONE_LOW);
  wire sel_mask_two = page_ext && (I_SFR_ADDR == `ADDR_MASK_TWO);
  wire sel_prio_two_low = page_ext && (I_SFR_ADDR == `ADDR_PRIO_TWO_LOW);
  wire sel_prio_one_high = page_ext && (I_SFR_ADDR == `ADDR_PRIO_ONE_HIGH);
  wire sel_prio_two_high = page_ext && (I_SFR_ADDR == `ADDR_PRIO_TWO_HIGH);
  wire any_sel = sel_mask_one || sel_prio_one_low || sel_mask_two ||
                 sel_prio_two_low || sel_prio_one_high || sel_prio_two_high;

  // Reserved positions are not stored, so a careless write cannot leak in
  wire [7:0] wdata_two = I_SFR_WDATA & `WMASK_PRIO_TWO;

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      mask_one_q <= `RST_PRIO;
      mask_two_q <= `RST_MASK_TWO;
      prio_one_low_q <= `RST_PRIO;
      prio_two_low_q <= `RST_PRIO;
      prio_one_high_q <= `RST_PRIO;
      prio_two_high_q <= `RST_PRIO;
    end
    else if (I_SFR_WR)
    begin
      if (sel_mask_one)
        mask_one_q <= I_SFR_WDATA;
      if (sel_mask_two)
        mask_two_q <= I_SFR_WDATA & `WMASK_TWO;
      if (sel_prio_one_low)
        prio_one_low_q <= I_SFR_WDATA;
      if (sel_prio_two_low)
        prio_two_low_q <= wdata_two;
      if (sel_prio_one_high)
        prio_one_high_q <= I_SFR_WDATA;
      if (sel_prio_two_high)
        prio_two_high_q <= wdata_two;
    end
  end

  wire [7:0] rdata_d = sel_mask_one ? mask_one_q :
                       sel_mask_two ? mask_two_q :
                       sel_prio_one_low ? prio_one_low_q :
                       sel_prio_two_low ? prio_two_low_q :
                       sel_prio_one_high ? prio_one_high_q :
                       sel_prio_two_high ? prio_two_high_q : 8'h00;

  // Read data is registered: answer one cycle after the read strobe
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      O_SFR_RDATA <= 8'h00;
      O_SFR_HIT <= 1'b0;
    end
    else
    begin
      O_SFR_RDATA <= I_SFR_RD ? rdata_d : 8'h00;
      O_SFR_HIT <= I_SFR_RD && any_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source gating and priority fields
  // Index 0..7 first bank (bit order 7..0 maps to index 7..0), 8..12 second bank

  logic [NUM_SRC-1:0] pend;
  ext_irq_bank_pkg::prio_t prio [NUM_SRC];

  wire timer5_raw = I_TIMER5_LOW_OVERFLOW_FLAG || I_TIMER5_HIGH_OVERFLOW_FLAG;
  wire timer4_raw = I_TIMER4_LOW_OVERFLOW_FLAG || I_TIMER4_HIGH_OVERFLOW_FLAG;

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_bank_one
      assign pend[g] = I_BANK_ONE_FLAGS[g] && mask_one_q[g];
      assign prio[g] = {prio_one_high_q[g], prio_one_low_q[g]};
    end
  endgenerate

  assign pend[8] = I_USB_FLAG && mask_two_q[`BIT_USB];
  assign pend[9] = I_SUPPLY_DETECT_FLAG && mask_two_q[`BIT_SUPPLY];
  assign pend[10] = timer4_raw && mask_two_q[`BIT_TIMER4];
  assign pend[11] = timer5_raw && mask_two_q[`BIT_TIMER5];
  assign pend[12] = I_CFG_LOGIC_FLAG && mask_two_q[`BIT_CFG_LOGIC];
  assign prio[8] = {prio_two_high_q[`BIT_USB], prio_two_low_q[`BIT_USB]};
  assign prio[9] = {prio_two_high_q[`BIT_SUPPLY], prio_two_low_q[`BIT_SUPPLY]};
  assign prio[10] = {prio_two_high_q[`BIT_TIMER4], prio_two_low_q[`BIT_TIMER4]};
  assign prio[11] = {prio_two_high_q[`BIT_TIMER5], prio_two_low_q[`BIT_TIMER5]};
  assign prio[12] = {prio_two_high_q[`BIT_CFG_LOGIC], prio_two_low_q[`BIT_CFG_LOGIC]};

  ////////////////////////////////////////////////////////////////////////////
  // Arbiter: highest level wins, lowest index wins a tie

  logic win_valid;
  logic [3:0] win_id;
  ext_irq_bank_pkg::prio_t win_lvl;

  always_comb
  begin
    win_valid = 1'b0;
    win_id = 4'h0;
    win_lvl = 2'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      // Descending scan with >= leaves the lowest index on ties
      if (pend[i] && (!win_valid || prio[i] >= win_lvl))
      begin
        win_valid = 1'b1;
        win_id = 4'(i);
        win_lvl = prio[i];
      end
    end
  end

  // During service only a strictly higher level may preempt
  wire may_preempt = !I_IN_SERVICE || (win_lvl > I_ACTIVE_LEVEL);
  wire req_d = win_valid && may_preempt;

  ext_irq_bank_pkg::arb_state_t state_q;
  ext_irq_bank_pkg::arb_state_t state_d;

  always_comb
  begin
    case (state_q)
      ext_irq_bank_pkg::ST_IDLE:
        state_d = req_d ? ext_irq_bank_pkg::ST_REQ : ext_irq_bank_pkg::ST_IDLE;
      ext_irq_bank_pkg::ST_REQ:
        state_d = req_d ? ext_irq_bank_pkg::ST_HOLD : ext_irq_bank_pkg::ST_IDLE;
      ext_irq_bank_pkg::ST_HOLD:
        state_d = req_d ? ext_irq_bank_pkg::ST_HOLD : ext_irq_bank_pkg::ST_IDLE;
      default:
        state_d = ext_irq_bank_pkg::ST_IDLE;
    endcase
  end

  // Request follows the winner with one cycle of latency; a flag that drops
  // is withdrawn the next cycle, so the core must sample on its own edge
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      state_q <= ext_irq_bank_pkg::ST_IDLE;
      O_IRQ_REQ <= 1'b0;
      O_IRQ_ID <= 4'h0;
      O_IRQ_LEVEL <= 2'h0;
    end
    else
    begin
      state_q <= state_d;
      O_IRQ_REQ <= req_d;
      O_IRQ_ID <= req_d ? win_id : 4'h0;
      O_IRQ_LEVEL <= req_d ? win_lvl : 2'h0;
    end
  end

endmodule : ext_irq_enable_priority_bank

// File: tb/ext_irq_bank_asserts.sv
// Port assertions for the extended interrupt bank
module ext_irq_bank_asserts (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RESETN,
  // Register port
  input wire logic [7:0] I_SFR_PAGE,
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic I_SFR_RD,
  input wire logic [7:0] O_SFR_RDATA,
  input wire logic O_SFR_HIT,
  // Requests and core
  input wire logic [7:0] I_BANK_ONE_FLAGS,
  input wire logic I_TIMER5_LOW_OVERFLOW_FLAG,
  input wire logic I_TIMER5_HIGH_OVERFLOW_FLAG,
  input wire logic I_TIMER4_LOW_OVERFLOW_FLAG,
  input wire logic I_TIMER4_HIGH_OVERFLOW_FLAG,
  input wire logic [1:0] I_ACTIVE_LEVEL,
  input wire logic I_IN_SERVICE,
  input wire logic O_IRQ_REQ,
  input wire logic [3:0] O_IRQ_ID,
  input wire logic [1:0] O_IRQ_LEVEL
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN);
  // Second-bank registers live only on the extended page
  wire two_rd = I_SFR_RD && I_SFR_PAGE == 8'h10 && I_SFR_ADDR inside {8'hCE, 8'hF4, 8'hF6};
  ext_hit_a: assert property (two_rd |=> O_SFR_HIT) else $error("no hit");
  rsvd_zero_a: assert property (two_rd |=> O_SFR_RDATA[5:4] == 2'h0) else $error("rsvd");
  idle_read_a: assert property (!I_SFR_RD |=> !O_SFR_HIT && O_SFR_RDATA == 8'h00)
    else $error("stray data");
  quiet_out_a: assert property (!O_IRQ_REQ |-> O_IRQ_ID == 4'h0 && O_IRQ_LEVEL == 2'h0)
    else $error("stray id");
  preempt_a: assert property (O_IRQ_REQ && $past(I_IN_SERVICE) |->
    O_IRQ_LEVEL > $past(I_ACTIVE_LEVEL)) else $error("low preempt");
  timer5_src_a: assert property (O_IRQ_REQ && O_IRQ_ID == 4'hB |->
    $past(I_TIMER5_LOW_OVERFLOW_FLAG || I_TIMER5_HIGH_OVERFLOW_FLAG)) else $error("t5");
  timer4_src_a: assert property (O_IRQ_REQ && O_IRQ_ID == 4'hA |->
    $past(I_TIMER4_LOW_OVERFLOW_FLAG || I_TIMER4_HIGH_OVERFLOW_FLAG)) else $error("t4");
  bank_src_a: assert property (O_IRQ_REQ && !O_IRQ_ID[3] |->
    |($past(I_BANK_ONE_FLAGS) & (8'h01 << O_IRQ_ID[2:0]))) else $error("bank id");
  cover property (O_IRQ_REQ && O_IRQ_LEVEL == 2'h3);
  cover property (O_IRQ_REQ && I_IN_SERVICE);
  cover property (two_rd ##1 O_SFR_HIT);
endmodule : ext_irq_bank_asserts
////////////////////////////////////////
bind ext_irq_enable_priority_bank ext_irq_bank_asserts chk_u (.*);

// File: tb/ext_irq_core_model.sv
// Behavioural core sequencer that takes and returns interrupts
module ext_irq_core_model (
  // Clock, reset and bench control
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_take,
  input wire logic i_ret,
  // Bank side
  input wire logic i_req,
  input wire logic [1:0] i_level,
  output logic o_in_service,
  output logic [1:0] o_active_level
);
  // Falling edge, so the bank always samples settled levels
  always_ff @(negedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      {o_in_service, o_active_level} <= 3'h0;
    else if (i_ret)
      o_in_service <= 1'b0;
    else if (i_take && i_req)
      {o_in_service, o_active_level} <= {1'b1, i_level};
  end
endmodule : ext_irq_core_model

// File: tb/ext_irq_enable_priority_bank_tb.sv
// Self-checking bench for the extended interrupt bank
module ext_irq_enable_priority_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, take = 0, ret = 0, t4h = 0, t5h = 0, hit, req, ins;
  logic [7:0] pg = 8'h10, ad = 8'h00, wd = 8'h00, bank = 8'h00, rdata;
  logic [12:8] fl = 5'h00;
  logic [3:0] id;
  logic [1:0] lvl, act;
  int bad_count = 0, checked = 0;
  ext_irq_enable_priority_bank dut_u (.I_CORE_CLK(clk), .I_RESETN(rst_n), .I_SFR_PAGE(pg),
    .I_SFR_ADDR(ad), .I_SFR_WR(wr), .I_SFR_RD(rd), .I_SFR_WDATA(wd), .O_SFR_RDATA(rdata),
    .O_SFR_HIT(hit), .I_BANK_ONE_FLAGS(bank), .I_TIMER5_LOW_OVERFLOW_FLAG(fl[11]),
    .I_TIMER5_HIGH_OVERFLOW_FLAG(t5h), .I_TIMER4_LOW_OVERFLOW_FLAG(fl[10]),
    .I_TIMER4_HIGH_OVERFLOW_FLAG(t4h), .I_CFG_LOGIC_FLAG(fl[12]), .I_SUPPLY_DETECT_FLAG(fl[9]),
    .I_USB_FLAG(fl[8]), .I_ACTIVE_LEVEL(act), .I_IN_SERVICE(ins), .O_IRQ_REQ(req),
    .O_IRQ_ID(id), .O_IRQ_LEVEL(lvl));
  ext_irq_core_model core_u (.i_clk(clk), .i_rst_n(rst_n), .i_take(take), .i_ret(ret),
    .i_req(req), .i_level(lvl), .o_in_service(ins), .o_active_level(act));
  initial forever #2 clk = ~clk;
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask : chk
  task automatic wreg(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {pg, ad, wd, wr} = {p, a, d, 1'b1};
    @(negedge clk);
    wr = 0;
  endtask : wreg
  task automatic rreg(input logic [7:0] p, input logic [7:0] a, input logic [7:0] e, input h);
    @(negedge clk);
    {pg, ad, rd} = {p, a, 1'b1};
    @(negedge clk);
    rd = 0;
    chk("rdata", rdata, e);
    chk("hit", {7'h00, hit}, {7'h00, h});
  endtask : rreg
  // Two falling edges: one for a register update, one for the registered request
  task automatic irq(input logic [3:0] i, input logic [1:0] l, input logic r);
    repeat (2) @(negedge clk);
    chk("req", {7'h00, req}, {7'h00, r});
    chk("id", {4'h0, id}, {4'h0, i});
    chk("level", {6'h00, lvl}, {6'h00, l});
  endtask : irq
  task automatic t_regs;
    rreg(8'h10, 8'hCE, 8'h00, 1);
    rreg(8'h10, 8'hF6, 8'h00, 1);
    rreg(8'h10, 8'hF5, 8'h00, 1);
    wreg(8'h10, 8'hF4, 8'h30);
    rreg(8'h10, 8'hF4, 8'h00, 1);
    wreg(8'h00, 8'hCE, 8'h4F);
    rreg(8'h10, 8'hCE, 8'h00, 1);
    rreg(8'h10, 8'h80, 8'h00, 0);
  endtask : t_regs
  task automatic t_ext;
    int b;
    for (int k = 8; k < 13; k++)
    begin
      b = (k == 12) ? 6 : k - 8;
      fl[k] = 1;
      irq(4'h0, 2'h0, 0);
      wreg(8'h10, 8'hCE, 8'h01 << b);
      wreg(8'h10, 8'hF4, 8'h01 << b);
      irq(4'(k), 2'h1, 1);
      wreg(8'h10, 8'hF6, 8'h01 << b);
      wreg(8'h10, 8'hF4, 8'h00);
      irq(4'(k), 2'h2, 1);
      fl[k] = 0;
    end
  endtask : t_ext
  task automatic t_pair;
    wreg(8'h10, 8'hCE, 8'h0C);
    t5h = 1;
    irq(4'hB, 2'h0, 1);
    t5h = 0;
    t4h = 1;
    irq(4'hA, 2'h0, 1);
    wreg(8'h10, 8'hCE, 8'h08);
    irq(4'h0, 2'h0, 0);
    t4h = 0;
  endtask : t_pair
  task automatic t_bank;
    wreg(8'h10, 8'hE6, 8'hFF);
    for (int i = 0; i < 8; i++)
    begin
      bank = 8'h01 << i;
      wreg(8'h10, 8'hF5, 8'h01 << i);
      irq(4'(i), 2'h2, 1);
    end
  endtask : t_bank
  // Tie at level 2, then service it and let only a higher level through
  task automatic t_arb;
    bank = 8'h81;
    wreg(8'h10, 8'hF5, 8'h81);
    irq(4'h0, 2'h2, 1);
    take <= 1;
    for (int n = 0; n < 4 && ins !== 1'b1; n++) @(negedge clk);
    take <= 0;
    chk("serv", {7'h00, ins}, 8'h01);
    irq(4'h0, 2'h0, 0);
    fl[8] = 1;
    wreg(8'h10, 8'hCE, 8'h01);
    wreg(8'h10, 8'hF4, 8'h01);
    wreg(8'h10, 8'hF6, 8'h01);
    irq(4'h8, 2'h3, 1);
  endtask : t_arb
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (3) @(negedge clk);
    rst_n = 1;
    t_regs;
    t_ext;
    t_pair;
    t_bank;
    t_arb;
    stop_test;
  end
endmodule : ext_irq_enable_priority_bank_tb
